// File: mhc_bank.sv
// Misc control low fields and headphone control register bank with lock interrupts.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "mhc_defs.svh"

module mhc_bank (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port.
  input wire mhc_pkg::mhc_bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  // Source clocks and converter status.
  input wire logic clk_xtal,
  input wire logic clk_pll_xtal,
  input wire logic clk_proc,
  input wire logic clk_engine,
  input wire logic clk_src_half,
  input wire logic clk_mod,
  input wire logic rate_converter_one_lock,
  input wire logic rate_converter_two_lock,
  // PWM path.
  input wire logic [3:0] pwm_in,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_ch_active,
  // Clock output, PLL, PWM pattern and DAC offset controls.
  output logic clk_ref_out,
  output logic pll_enable,
  output logic pwm_pattern_en,
  output logic dac_mod_offset_off,
  // Headphone controls.
  output mhc_pkg::mhc_hp_ctrl_type headphone_one_ctrl,
  // Interrupt.
  output logic irq
);
  logic [15:0] misc_q;
  logic [15:0] hp_q;
  logic [1:0] lock_q;
  logic [1:0] lock_prev_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic [3:0] irq_evt;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic [15:0] misc_view;
  logic sel_clk;
  mhc_pkg::mhc_clk_src_type clk_src;

  wire wr_misc = bus_req.wr && bus_req.addr == `MHC_OFF_MISC;
  wire wr_hp = bus_req.wr && bus_req.addr == `MHC_OFF_HP;
  wire wr_clr = bus_req.wr && bus_req.addr == `MHC_OFF_IRQ_CLR;
  wire wr_en = bus_req.wr && bus_req.addr == `MHC_OFF_IRQ_EN;

  // Lock bits are kept out of the stored copy so writes cannot touch them.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      misc_q <= `MHC_MISC_RST;
    end else if (wr_misc) begin
      misc_q <= bus_req.wdata & `MHC_MISC_WMASK;
    end
  end

  // Stored fields change only on a write to their own address.
  a_misc_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_misc |=> misc_q == ($past(bus_req.wdata) & `MHC_MISC_WMASK))
    else $error("misc register not loaded from masked write");

  a_misc_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !wr_misc |=> $stable(misc_q))
    else $error("misc register changed without a write");

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hp_q <= `MHC_HP_RST;
    end else if (wr_hp) begin
      hp_q <= {8'h00, bus_req.wdata[7:0]};
    end
  end

  // Headphone controls follow the register one cycle after the write.
  a_hp_unmute: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp && !bus_req.wdata[`MHC_BIT_HP_MUTE] |=> !headphone_one_ctrl.mute)
    else $error("mute still set after clearing write");

  a_hp_atten: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp && bus_req.wdata[4:0] != `MHC_HP_GAIN_PLUS |=> !headphone_one_ctrl.gain_boost &&
    headphone_one_ctrl.atten_steps == $past(bus_req.wdata[4:0]))
    else $error("attenuation code not passed through");

  a_hp_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !wr_hp |=> $stable(headphone_one_ctrl))
    else $error("headphone controls changed without a write");

  a_hp_rst_mute: assert property (@(posedge clk_sys)
    $rose(nrst) |-> !headphone_one_ctrl.mute)
    else $error("headphone not unmuted after reset");

  a_hp_rst_scp: assert property (@(posedge clk_sys)
    $rose(nrst) |-> !headphone_one_ctrl.short_protect)
    else $error("short protect on after reset");

  a_hp_rst_tri: assert property (@(posedge clk_sys)
    $rose(nrst) |-> headphone_one_ctrl.tristate)
    else $error("tristating not in effect after reset");

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lock_q <= 2'h0;
      lock_prev_q <= 2'h0;
    end else begin
      lock_q <= {rate_converter_two_lock, rate_converter_one_lock};
      lock_prev_q <= lock_q;
    end
  end

  a_lock_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> lock_q == {$past(rate_converter_two_lock), $past(rate_converter_one_lock)})
    else $error("lock flags do not follow the converters");

  a_lock_reset: assert property (@(posedge clk_sys)
    $rose(nrst) |-> lock_q == 2'h0)
    else $error("lock flags not clear after reset");

  // Events: bit0/1 gain lock of converter one/two, bit2/3 lose it.
  assign irq_evt = {lock_prev_q & ~lock_q, lock_q & ~lock_prev_q};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_stat_q <= 4'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? bus_req.wdata[3:0] : 4'h0)) | irq_evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_en_q <= 4'h0;
    end else if (wr_en) begin
      irq_en_q <= bus_req.wdata[3:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // A new event must survive a clear written in the same cycle.
  a_evt_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    |irq_evt |=> (irq_stat_q & $past(irq_evt)) == $past(irq_evt))
    else $error("lock event lost from status");

  a_irq_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_clr && irq_evt == 4'h0 |=> (irq_stat_q & $past(bus_req.wdata[3:0])) == 4'h0)
    else $error("status bit not cleared by write of one");

  a_irq_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_en |=> irq_en_q == $past(bus_req.wdata[3:0]))
    else $error("interrupt enable not loaded");

  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    irq_en_q == 4'h0 |-> !irq)
    else $error("interrupt raised with nothing enabled");

  always_comb begin
    misc_view = misc_q;
    misc_view[`MHC_BIT_LOCK2] = lock_q[1];
    misc_view[`MHC_BIT_LOCK1] = lock_q[0];
  end

  always_comb begin
    rdata_d = 16'h0000;
    unique case (bus_req.addr)
      `MHC_OFF_MISC: rdata_d = misc_view;
      `MHC_OFF_HP: rdata_d = hp_q;
      `MHC_OFF_IRQ_STAT: rdata_d = {12'h000, irq_stat_q};
      `MHC_OFF_IRQ_EN: rdata_d = {12'h000, irq_en_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (bus_req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign bus_rdata = rdata_q;

  // Read data stand only in the cycle after the read strobe.
  a_rd_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !bus_req.rd |=> bus_rdata == 16'h0000)
    else $error("read data present without a read");

  a_rd_hp: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_req.rd && bus_req.addr == `MHC_OFF_HP |=> bus_rdata == $past(hp_q))
    else $error("headphone read data wrong");

  a_rd_b15: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_req.rd && bus_req.addr == `MHC_OFF_MISC |=> !bus_rdata[15])
    else $error("unimplemented ready flag reads set");

  a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_req.rd && bus_req.addr != `MHC_OFF_MISC && bus_req.addr != `MHC_OFF_HP &&
    bus_req.addr != `MHC_OFF_IRQ_STAT && bus_req.addr != `MHC_OFF_IRQ_EN |=>
    bus_rdata == 16'h0000)
    else $error("unmapped read returned data");

  // Channel gating by own enable and global enable.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pwm
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          pwm_ch_active[gi] <= 1'b0;
          pwm_out[gi] <= 1'b0;
        end else begin
          pwm_ch_active[gi] <= misc_q[`MHC_BIT_PWM_CH_LO + gi] &&
                               misc_q[`MHC_BIT_PWM_GLOBAL];
          pwm_out[gi] <= pwm_in[gi] && misc_q[`MHC_BIT_PWM_CH_LO + gi] &&
                         misc_q[`MHC_BIT_PWM_GLOBAL];
        end
      end
    end
  endgenerate

  a_pwm_active: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> pwm_ch_active ==
    ($past(misc_q[10:7]) & {4{$past(misc_q[`MHC_BIT_PWM_GLOBAL])}}))
    else $error("channel active state does not follow the enables");

  a_pwm_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> pwm_out == ($past(pwm_in) & pwm_ch_active))
    else $error("enabled channel does not pass its stream");

  a_pwm_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pwm_out & ~pwm_ch_active) == 4'h0)
    else $error("disabled channel output not at ground");

  always_comb begin
    unique casez (misc_q[3:1])
      3'b000: clk_src = mhc_pkg::MHC_SEL_XTAL;
      3'b001: clk_src = mhc_pkg::MHC_SEL_PROC;
      3'b010: clk_src = mhc_pkg::MHC_SEL_ENGINE;
      3'b011: clk_src = mhc_pkg::MHC_SEL_SRC_HALF;
      default: clk_src = mhc_pkg::MHC_SEL_MOD;
    endcase
  end

  always_comb begin
    unique case (clk_src)
      mhc_pkg::MHC_SEL_XTAL: sel_clk = clk_pll_xtal;
      mhc_pkg::MHC_SEL_PROC: sel_clk = clk_proc;
      mhc_pkg::MHC_SEL_ENGINE: sel_clk = clk_engine;
      mhc_pkg::MHC_SEL_SRC_HALF: sel_clk = clk_src_half;
      default: sel_clk = clk_mod;
    endcase
  end

  // The output clock path is combinational so the source rate is passed through.
  assign clk_ref_out = misc_q[`MHC_BIT_CLK_OUT_EN] &&
                       (misc_q[`MHC_BIT_CLK_TYPE] ? sel_clk : clk_xtal);

  assign pll_enable = misc_q[`MHC_BIT_PLL_EN];
  assign pwm_pattern_en = misc_q[`MHC_BIT_PWM_PATTERN];
  assign dac_mod_offset_off = misc_q[`MHC_BIT_DAC_OFFSET_OFF];

  a_sel_xtal: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[3:1] == 3'b000 |-> clk_src == mhc_pkg::MHC_SEL_XTAL)
    else $error("zero select not crystal clock");

  a_sel_proc: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[3:1] == 3'b001 |-> clk_src == mhc_pkg::MHC_SEL_PROC)
    else $error("select one not processor clock");

  a_sel_engine: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[3:1] == 3'b010 |-> clk_src == mhc_pkg::MHC_SEL_ENGINE)
    else $error("select two not engine clock");

  a_sel_half: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[3:1] == 3'b011 |-> clk_src == mhc_pkg::MHC_SEL_SRC_HALF)
    else $error("select three not half converter clock");

  a_clk_internal: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[`MHC_BIT_CLK_OUT_EN] && misc_q[`MHC_BIT_CLK_TYPE] && misc_q[3:1] == 3'b001 |->
    clk_ref_out == clk_proc)
    else $error("processor clock not routed to the output");

  always_comb begin
    headphone_one_ctrl.mute = hp_q[`MHC_BIT_HP_MUTE];
    headphone_one_ctrl.short_protect = hp_q[`MHC_BIT_HP_SCP];
    headphone_one_ctrl.tristate = !hp_q[`MHC_BIT_HP_NOTRI];
    headphone_one_ctrl.gain_boost = hp_q[4:0] == `MHC_HP_GAIN_PLUS;
    headphone_one_ctrl.atten_steps = (hp_q[4:0] == `MHC_HP_GAIN_PLUS) ? 5'h00 : hp_q[4:0];
  end

  a_pwm_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !misc_q[`MHC_BIT_PWM_GLOBAL] |=> pwm_out == 4'h0)
    else $error("pwm output active without global enable");
  a_pwm_reset: assert property (@(posedge clk_sys)
    $rose(nrst) |-> pwm_out == 4'h0 && misc_q[10:7] == 4'h0)
    else $error("pwm not idle after reset");
  a_lock_live: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_req.rd && bus_req.addr == `MHC_OFF_MISC |=>
    bus_rdata[6:5] == $past(lock_q))
    else $error("lock read does not match live state");
  a_lock_ro: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_misc |=> misc_q[6:5] == 2'h0)
    else $error("lock bits stored from write");
  a_clk_off: assert property (@(posedge clk_sys) disable iff (!nrst)
    !misc_q[`MHC_BIT_CLK_OUT_EN] |-> !clk_ref_out)
    else $error("clock out while disabled");
  a_sel_mod: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[3] |-> clk_src == mhc_pkg::MHC_SEL_MOD)
    else $error("1xx select not modulator clock");
  a_clk_type: assert property (@(posedge clk_sys) disable iff (!nrst)
    misc_q[`MHC_BIT_CLK_OUT_EN] && !misc_q[`MHC_BIT_CLK_TYPE] |-> clk_ref_out == clk_xtal)
    else $error("crystal not routed when type is zero");
  a_hp_mute: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp && bus_req.wdata[7] |=> headphone_one_ctrl.mute)
    else $error("mute not immediate");
  a_hp_tri: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp |=> headphone_one_ctrl.tristate == !$past(bus_req.wdata[5]))
    else $error("tristate sense wrong");
  a_hp_scp: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp |=> headphone_one_ctrl.short_protect == $past(bus_req.wdata[6]))
    else $error("short protect not following write");
  a_hp_gain: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hp && bus_req.wdata[4:0] == `MHC_HP_GAIN_PLUS |=> headphone_one_ctrl.gain_boost &&
    headphone_one_ctrl.atten_steps == 5'h00)
    else $error("code 31 not mapped to boost");
endmodule

// File: mhc_defs.svh
// Register offsets, field positions and reset values of the misc and headphone control bank.
`ifndef MHC_DEFS_SVH
`define MHC_DEFS_SVH
`define MHC_ADDR_W 8
`define MHC_OFF_MISC 8'h0a
`define MHC_OFF_HP 8'h0b
`define MHC_OFF_IRQ_STAT 8'h20
`define MHC_OFF_IRQ_CLR 8'h21
`define MHC_OFF_IRQ_EN 8'h22
`define MHC_MISC_RST 16'h0800
`define MHC_HP_RST 16'h0000
`define MHC_MISC_WMASK 16'h7f9f
`define MHC_BIT_PWM_GLOBAL 14
`define MHC_BIT_CLK_TYPE 13
`define MHC_BIT_PWM_CH_LO 7
`define MHC_BIT_LOCK2 6
`define MHC_BIT_LOCK1 5
`define MHC_BIT_CLK_OUT_EN 4
`define MHC_BIT_CLK_SEL_LO 1
`define MHC_BIT_PLL_EN 0
`define MHC_BIT_PWM_PATTERN 12
`define MHC_BIT_DAC_OFFSET_OFF 11
`define MHC_BIT_HP_MUTE 7
`define MHC_BIT_HP_SCP 6
`define MHC_BIT_HP_NOTRI 5
`define MHC_HP_GAIN_PLUS 5'h1f
`define MHC_IRQ_W 4
`endif

// File: mhc_pkg.sv
// Types shared by the misc and headphone control bank.
package mhc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mhc_bus_req_type;

  typedef struct packed {
    logic mute;
    logic short_protect;
    logic tristate;
    logic gain_boost;
    logic [4:0] atten_steps;
  } mhc_hp_ctrl_type;

  typedef enum logic [2:0] {
    MHC_SEL_XTAL, MHC_SEL_PROC, MHC_SEL_ENGINE, MHC_SEL_SRC_HALF, MHC_SEL_MOD
  } mhc_clk_src_type;
endpackage

// File: tb_misc_and_headphone_control.sv
// Self-checking testbench for the misc and headphone control bank.
`timescale 1ns/1ns
`include "mhc_defs.svh"
module tb_misc_and_headphone_control;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  mhc_pkg::mhc_bus_req_type bus_req = '0;
  logic [15:0] bus_rdata;
  logic [5:0] src = 6'h00;
  logic lk1 = 1'b0;
  logic lk2 = 1'b0;
  logic [3:0] pwm_in = 4'hf;
  logic [3:0] pwm_out;
  logic [3:0] act;
  logic ref_out;
  logic pll_en;
  logic pat;
  logic dmo;
  mhc_pkg::mhc_hp_ctrl_type hp;
  logic irq;
  int errors = 0;
  int total_checks = 0;
  logic [15:0] d;
  logic [24:0] rows [8] = '{{16'h0000, 9'h040}, {16'h0080, 9'h140}, {16'h0040, 9'h0c0},
    {16'h0020, 9'h000}, {16'h001e, 9'h05e}, {16'h001f, 9'h060}, {16'h00ff, 9'h1a0},
    {16'h0001, 9'h041}};

  mhc_bank dut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .clk_xtal(src[0]), .clk_pll_xtal(src[1]), .clk_proc(src[2]), .clk_engine(src[3]),
    .clk_src_half(src[4]), .clk_mod(src[5]), .rate_converter_one_lock(lk1),
    .rate_converter_two_lock(lk2), .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_ch_active(act),
    .clk_ref_out(ref_out), .pll_enable(pll_en), .pwm_pattern_en(pat), .dac_mod_offset_off(dmo),
    .headphone_one_ctrl(hp), .irq(irq));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      wr(`MHC_OFF_HP, rows[r][24:9]);
      chk({7'h00, hp}, {7'h00, rows[r][8:0]});
      rd(`MHC_OFF_HP, d);
      chk(d, rows[r][24:9] & 16'h00ff);
    end
    $display("headphone rows done");
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 chk({7'h00, hp}, 16'h0040);
    chk({pwm_out, act, 7'h00, irq}, 16'h0000);
    chk({14'h0000, pat, dmo}, 16'h0001);
    rd(`MHC_OFF_MISC, d);
    chk(d, `MHC_MISC_RST);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      wr(`MHC_OFF_MISC, {1'b0, i[4], 3'h0, i[3:0], 7'h00});
      repeat (2) @(posedge clk_sys);
      #1 chk({12'h000, act}, {12'h000, i[3:0] & {4{i[4]}}});
      chk({12'h000, pwm_out}, {12'h000, i[3:0] & {4{i[4]}}});
    end
    @(posedge clk_sys) pwm_in <= 4'h5;
    @(posedge clk_sys);
    #1 chk({12'h000, pwm_out}, 16'h0005);
    $display("pwm test done");
    for (int i = 0; i < 8; i++) begin
      wr(`MHC_OFF_MISC, 16'h2011 | (16'(i) << 1));
      @(posedge clk_sys) src <= 6'h01 << ((i > 3) ? 5 : i + 1);
      #1 chk({15'h0000, ref_out}, 16'h0001);
      @(posedge clk_sys) src <= ~(6'h01 << ((i > 3) ? 5 : i + 1));
      #1 chk({15'h0000, ref_out}, 16'h0000);
      chk({15'h0000, pll_en}, 16'h0001);
    end
    wr(`MHC_OFF_MISC, 16'h0010);
    @(posedge clk_sys) src <= 6'h01;
    #1 chk({15'h0000, ref_out}, 16'h0001);
    wr(`MHC_OFF_MISC, 16'h2000);
    @(posedge clk_sys) src <= 6'h3f;
    #1 chk({15'h0000, ref_out}, 16'h0000);
    chk({13'h0000, pat, dmo, pll_en}, 16'h0000);
    wr(`MHC_OFF_MISC, 16'h1801);
    chk({13'h0000, pat, dmo, pll_en}, 16'h0007);
    $display("clock output test done");
    wr(`MHC_OFF_MISC, 16'h0060);
    rd(`MHC_OFF_MISC, d);
    chk(d, 16'h0000);
    @(posedge clk_sys) lk1 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`MHC_OFF_MISC, d);
    chk(d, 16'h0020);
    @(posedge clk_sys) lk2 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`MHC_OFF_MISC, d);
    chk(d, 16'h0060);
    rd(`MHC_OFF_IRQ_STAT, d);
    chk(d, 16'h0003);
    chk({15'h0000, irq}, 16'h0000);
    wr(`MHC_OFF_IRQ_EN, 16'h0001);
    @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0001);
    wr(`MHC_OFF_IRQ_CLR, 16'h0003);
    @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0000);
    @(posedge clk_sys) lk1 <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0000);
    rd(`MHC_OFF_IRQ_STAT, d);
    chk(d, 16'h0004);
    wr(`MHC_OFF_IRQ_EN, 16'h0004);
    @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0001);
    rd(8'h30, d);
    chk(d, 16'h0000);
    $display("lock and interrupt test done");
    summarize();
  end
endmodule
